//--- core/sflash_pkg.sv
// Purpose: Shared constants and types of the serial flash pin interface.
// Assumes: Array address width of at least 15 bits.
// Notes:   Command codes and status bit positions are local conventions.
package sflash_pkg;
  localparam int         ADDR_W_DEF        = 15;
  localparam int         OTP_BYTES         = 128;
  localparam int         OTP_FACTORY_BYTES = 64;
  localparam int         PAGE_BYTES        = 256;
  localparam int         ERASE_4K_BYTES    = 4096;
  localparam int         ERASE_32K_BYTES   = 32768;
  localparam logic [8:0] PAGE_CNT          = 9'h100;
  localparam logic [8:0] BYTE_IDX_MAX      = 9'h1ff;
  localparam logic [8:0] ADDR_LAST_IDX     = 9'h003;
  localparam logic [8:0] DATA_IDX          = 9'h004;
  localparam logic [8:0] DUAL_DATA_IDX     = 9'h005;
  localparam logic [8:0] STATUS_IDX        = 9'h001;
  localparam logic [7:0] CMD_WRITE_EN      = 8'h06;
  localparam logic [7:0] CMD_STATUS        = 8'h05;
  localparam logic [7:0] CMD_READ          = 8'h03;
  localparam logic [7:0] CMD_READ_DUAL     = 8'h3b;
  localparam logic [7:0] CMD_PROG          = 8'h02;
  localparam logic [7:0] CMD_ERASE_PAGE    = 8'h81;
  localparam logic [7:0] CMD_ERASE_4K      = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K     = 8'h52;
  localparam logic [7:0] CMD_ERASE_CHIP    = 8'h60;
  localparam logic [7:0] CMD_OTP_PROG      = 8'h9b;
  localparam logic [7:0] CMD_OTP_READ      = 8'h77;
  localparam int         STAT_BUSY_BIT     = 0;
  localparam int         STAT_WEL_BIT      = 1;
  localparam int         STAT_FAIL_BIT     = 5;
  localparam logic [7:0] ERASED_BYTE       = 8'hff;
  // Arbitrary seed for the factory identifier pattern
  localparam logic [7:0] OTP_ID_SEED       = 8'h5a;
  localparam logic       CS_IDLE           = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE, OP_WREN, OP_PROG, OP_OTP_PROG,
    OP_ERASE_PAGE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_CHIP
  } op_kind_e;

  typedef enum logic [1:0] {ENG_IDLE, ENG_PROG, ENG_OTP, ENG_ERASE} eng_state_e;

  function automatic op_kind_e cmd_kind(input logic [7:0] c);
    case (c)
      CMD_WRITE_EN:   cmd_kind = OP_WREN;
      CMD_PROG:       cmd_kind = OP_PROG;
      CMD_OTP_PROG:   cmd_kind = OP_OTP_PROG;
      CMD_ERASE_PAGE: cmd_kind = OP_ERASE_PAGE;
      CMD_ERASE_4K:   cmd_kind = OP_ERASE_4K;
      CMD_ERASE_32K:  cmd_kind = OP_ERASE_32K;
      CMD_ERASE_CHIP: cmd_kind = OP_ERASE_CHIP;
      default:        cmd_kind = OP_NONE;
    endcase
  endfunction
endpackage

//--- core/sflash_sync.sv
// Purpose: Two-stage level synchroniser.
// Assumes: Input is a slow level, held for several destination clocks.
// Notes:   Only the second stage may be read.
`timescale 1ns/1ps
module sflash_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= INIT;
      q_ff    <= INIT;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

//--- core/serial_flash_pin_interface.sv
// Purpose: Device-side pin front end of a small serial flash with its array and engine.
// Assumes: SCK is the link clock; CS_N acts asynchronously on link logic, HOLD_N asynchronously only on the output launch flops.
// Notes:   The array is read across domains only while the engine is idle.
`timescale 1ns/1ps
module serial_flash_pin_interface #(
  parameter int ADDR_W = sflash_pkg::ADDR_W_DEF
) (
  input  wire logic CORE_CLK,
  input  wire logic RST,
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic HOLD_N,
  input  wire logic SI_IN,
  output logic      DUAL_LANE_LOW,
  output logic      DUAL_LANE_LOW_OE_N,
  output logic      SO,
  output logic      SO_OE_N,
  output logic      STANDBY,
  output logic      BUSY
);
  localparam int MEM_BYTES = 1 << ADDR_W;

  // Storage
  logic [7:0]              mem   [MEM_BYTES];
  logic [7:0]              otp   [sflash_pkg::OTP_BYTES];
  logic [7:0]              pbuf  [sflash_pkg::PAGE_BYTES];

  // Link frame state, cleared while deselected
  logic                    lrst;
  logic                    orst;
  logic [2:0]              bit_cnt_ff, nxt_bit_cnt;
  logic [7:0]              shreg_ff, nxt_shreg;
  logic [8:0]              byte_idx_ff, nxt_byte_idx;
  logic [7:0]              cmd_ff, nxt_cmd;
  logic [23:0]             addr_ff, nxt_addr;
  logic [ADDR_W-1:0]       rd_addr_ff, nxt_rd_addr;
  logic [8:0]              wcnt_ff, nxt_wcnt;
  logic [7:0]              wptr_ff, nxt_wptr;
  logic [7:0]              sh;
  logic [8:0]              first_data;
  logic                    dual_data;
  logic                    last;
  logic                    pb_we;
  logic [7:0]              pb_wa;

  // Operation handed to the engine, kept across deselect
  logic                    op_valid_ff, nxt_op_valid;
  sflash_pkg::op_kind_e    op_kind_ff, nxt_op_kind;
  logic [23:0]             op_addr_ff, nxt_op_addr;
  logic [8:0]              op_cnt_ff, nxt_op_cnt;

  // Output launch state
  logic                    so_ff, nxt_so;
  logic                    so_oe_n_ff, nxt_so_oe_n;
  logic                    lo_ff, nxt_lo;
  logic                    lo_oe_n_ff, nxt_lo_oe_n;
  logic [7:0]              tx_byte;
  logic                    tx_on;
  logic                    tx_dual;
  logic [2:0]              hi_idx;
  logic [2:0]              lo_idx;
  logic [2:0]              st_s;
  logic [7:0]              stat;

  // Core engine
  logic                    cs_s;
  logic                    cs_d_ff, nxt_cs_d;
  sflash_pkg::eng_state_e  state_ff, nxt_state;
  logic                    wel_ff, nxt_wel;
  logic                    fail_ff, nxt_fail;
  logic                    busy_ff, nxt_busy;
  logic                    standby_ff, nxt_standby;
  logic [ADDR_W-1:0]       ptr_ff, nxt_ptr;
  logic [ADDR_W:0]         left_ff, nxt_left;
  logic [7:0]              pofs_ff, nxt_pofs;
  logic                    mem_we;
  logic [ADDR_W-1:0]       mem_wa;
  logic [7:0]              mem_wd;
  logic                    otp_we;
  logic [6:0]              otp_wa;
  logic [7:0]              otp_wd;
  logic [7:0]              pdat;
  logic                    cs_rise;

  function automatic logic [ADDR_W:0] erase_size(input sflash_pkg::op_kind_e k);
    case (k)
      sflash_pkg::OP_ERASE_PAGE: erase_size = (ADDR_W+1)'(sflash_pkg::PAGE_BYTES);
      sflash_pkg::OP_ERASE_4K:   erase_size = (ADDR_W+1)'(sflash_pkg::ERASE_4K_BYTES);
      sflash_pkg::OP_ERASE_32K:  erase_size = (ADDR_W+1)'(sflash_pkg::ERASE_32K_BYTES);
      default:                   erase_size = (ADDR_W+1)'(MEM_BYTES);
    endcase
  endfunction

  assign lrst = RST | CS_N;
  assign orst = RST | CS_N | ~HOLD_N;

  sflash_sync #(.WIDTH(1), .INIT(sflash_pkg::CS_IDLE)) u_cs_sync (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CS_N),
    .q   (cs_s)
  );

  // Status is only sampled while SCK runs, so it lags by two link edges
  sflash_sync #(.WIDTH(3), .INIT(3'h0)) u_st_sync (
    .clk (SCK),
    .rst (RST),
    .d   ({fail_ff, wel_ff, busy_ff}),
    .q   (st_s)
  );

  // Link capture on rising edges, both clock modes alike
  always_comb begin
    sh           = {shreg_ff[6:0], SI_IN};
    first_data   = (cmd_ff == sflash_pkg::CMD_READ_DUAL) ? sflash_pkg::DUAL_DATA_IDX : sflash_pkg::DATA_IDX;
    dual_data    = (cmd_ff == sflash_pkg::CMD_READ_DUAL) && (byte_idx_ff >= sflash_pkg::DUAL_DATA_IDX);
    last         = dual_data ? (bit_cnt_ff == 3'h3) : (bit_cnt_ff == 3'h7);
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_shreg    = shreg_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_cmd      = cmd_ff;
    nxt_addr     = addr_ff;
    nxt_rd_addr  = rd_addr_ff;
    nxt_wcnt     = wcnt_ff;
    nxt_wptr     = wptr_ff;
    pb_we        = 1'b0;
    pb_wa        = addr_ff[7:0] + wptr_ff;
    if (HOLD_N) begin
      nxt_bit_cnt = last ? 3'h0 : bit_cnt_ff + 3'h1;
      nxt_shreg   = sh;
      if (last) begin
        if (byte_idx_ff != sflash_pkg::BYTE_IDX_MAX) begin
          nxt_byte_idx = byte_idx_ff + 9'h001;
        end
        if (byte_idx_ff == 9'h000) begin
          nxt_cmd = sh;
        end else if (byte_idx_ff <= sflash_pkg::ADDR_LAST_IDX) begin
          nxt_addr = {addr_ff[15:0], sh};
          if (byte_idx_ff == sflash_pkg::ADDR_LAST_IDX) begin
            nxt_rd_addr = nxt_addr[ADDR_W-1:0];
          end
        end else if (byte_idx_ff >= first_data) begin
          nxt_rd_addr = rd_addr_ff + ADDR_W'(1);
          if ((cmd_ff == sflash_pkg::CMD_PROG || cmd_ff == sflash_pkg::CMD_OTP_PROG) && !st_s[0]) begin
            pb_we    = 1'b1;
            nxt_wptr = wptr_ff + 8'h01;  // Wraps inside the page
            if (wcnt_ff != sflash_pkg::PAGE_CNT) begin
              nxt_wcnt = wcnt_ff + 9'h001;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge SCK or posedge lrst) begin
    if (lrst) begin
      bit_cnt_ff  <= 3'h0;
      shreg_ff    <= 8'h00;
      byte_idx_ff <= 9'h000;
      cmd_ff      <= 8'h00;
      addr_ff     <= 24'h000000;
      rd_addr_ff  <= '0;
      wcnt_ff     <= 9'h000;
      wptr_ff     <= 8'h00;
    end else begin
      bit_cnt_ff  <= nxt_bit_cnt;
      shreg_ff    <= nxt_shreg;
      byte_idx_ff <= nxt_byte_idx;
      cmd_ff      <= nxt_cmd;
      addr_ff     <= nxt_addr;
      rd_addr_ff  <= nxt_rd_addr;
      wcnt_ff     <= nxt_wcnt;
      wptr_ff     <= nxt_wptr;
    end
  end

  // Page buffer keeps no reset: it is plain storage
  always_ff @(posedge SCK) begin
    if (pb_we) begin
      pbuf[pb_wa] <= sh;
    end
  end

  // A frame must end on a byte boundary, so any started byte withdraws the offer
  always_comb begin
    nxt_op_valid = op_valid_ff;
    nxt_op_kind  = op_kind_ff;
    nxt_op_addr  = op_addr_ff;
    nxt_op_cnt   = op_cnt_ff;
    if (HOLD_N && !CS_N) begin
      if (bit_cnt_ff == 3'h0) begin
        nxt_op_valid = 1'b0;
      end
      if (last) begin
        if (byte_idx_ff == 9'h000) begin
          nxt_op_kind  = sflash_pkg::cmd_kind(sh);
          nxt_op_valid = (nxt_op_kind == sflash_pkg::OP_WREN) || (nxt_op_kind == sflash_pkg::OP_ERASE_CHIP);
        end else if (byte_idx_ff == sflash_pkg::ADDR_LAST_IDX) begin
          nxt_op_addr  = {addr_ff[15:0], sh};
          nxt_op_valid = (op_kind_ff == sflash_pkg::OP_ERASE_PAGE) || (op_kind_ff == sflash_pkg::OP_ERASE_4K)
                         || (op_kind_ff == sflash_pkg::OP_ERASE_32K);
        end else if (byte_idx_ff > sflash_pkg::ADDR_LAST_IDX && pb_we) begin
          nxt_op_cnt   = nxt_wcnt;
          nxt_op_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      op_valid_ff <= 1'b0;
      op_kind_ff  <= sflash_pkg::OP_NONE;
      op_addr_ff  <= 24'h000000;
      op_cnt_ff   <= 9'h000;
    end else begin
      op_valid_ff <= nxt_op_valid;
      op_kind_ff  <= nxt_op_kind;
      op_addr_ff  <= nxt_op_addr;
      op_cnt_ff   <= nxt_op_cnt;
    end
  end

  // Output launch on falling edges; in mode 3 the first fall finds no data phase
  always_comb begin
    stat                           = 8'h00;
    stat[sflash_pkg::STAT_BUSY_BIT] = st_s[0];
    stat[sflash_pkg::STAT_WEL_BIT]  = st_s[1];
    stat[sflash_pkg::STAT_FAIL_BIT] = st_s[2];
    tx_byte = mem[rd_addr_ff];
    tx_on   = 1'b0;
    tx_dual = 1'b0;
    if (cmd_ff == sflash_pkg::CMD_STATUS) begin
      tx_byte = stat;
      tx_on   = byte_idx_ff >= sflash_pkg::STATUS_IDX;
    end else if (cmd_ff == sflash_pkg::CMD_READ) begin
      tx_on   = byte_idx_ff >= sflash_pkg::DATA_IDX;
    end else if (cmd_ff == sflash_pkg::CMD_OTP_READ) begin
      tx_byte = otp[rd_addr_ff[6:0]];
      tx_on   = byte_idx_ff >= sflash_pkg::DATA_IDX;
    end else if (cmd_ff == sflash_pkg::CMD_READ_DUAL) begin
      tx_on   = dual_data;
      tx_dual = 1'b1;
    end
    hi_idx      = tx_dual ? 3'h7 - {bit_cnt_ff[1:0], 1'b0} : 3'h7 - bit_cnt_ff;
    lo_idx      = hi_idx - 3'h1;
    nxt_so      = tx_on & tx_byte[hi_idx];
    nxt_so_oe_n = ~tx_on;
    nxt_lo      = tx_on & tx_dual & tx_byte[lo_idx];
    nxt_lo_oe_n = ~(tx_on & tx_dual);
  end

  always_ff @(negedge SCK or posedge orst) begin
    if (orst) begin
      so_ff      <= 1'b0;
      so_oe_n_ff <= 1'b1;
      lo_ff      <= 1'b0;
      lo_oe_n_ff <= 1'b1;
    end else begin
      so_ff      <= nxt_so;
      so_oe_n_ff <= nxt_so_oe_n;
      lo_ff      <= nxt_lo;
      lo_oe_n_ff <= nxt_lo_oe_n;
    end
  end

  // Engine: the offer is stable once CS_N is high, so the synchronised rise qualifies it
  always_comb begin
    cs_rise     = cs_s & ~cs_d_ff;
    nxt_cs_d    = cs_s;
    nxt_state   = state_ff;
    nxt_wel     = wel_ff;
    nxt_fail    = fail_ff;
    nxt_ptr     = ptr_ff;
    nxt_left    = left_ff;
    nxt_pofs    = pofs_ff;
    mem_we      = 1'b0;
    mem_wa      = ptr_ff;
    mem_wd      = sflash_pkg::ERASED_BYTE;
    otp_we      = 1'b0;
    otp_wa      = pofs_ff[6:0];
    otp_wd      = sflash_pkg::ERASED_BYTE;
    pdat        = pbuf[pofs_ff];
    case (state_ff)
      sflash_pkg::ENG_IDLE: begin
        if (cs_rise && op_valid_ff) begin
          if (op_kind_ff == sflash_pkg::OP_WREN) begin
            nxt_wel = 1'b1;
          end else if (wel_ff) begin
            nxt_fail = 1'b0;
            nxt_pofs = op_addr_ff[7:0];
            nxt_left = (ADDR_W+1)'(op_cnt_ff);
            nxt_ptr  = op_addr_ff[ADDR_W-1:0];
            if (op_kind_ff == sflash_pkg::OP_PROG) begin
              nxt_state = sflash_pkg::ENG_PROG;
            end else if (op_kind_ff == sflash_pkg::OP_OTP_PROG) begin
              nxt_state = sflash_pkg::ENG_OTP;
            end else begin
              nxt_left  = erase_size(op_kind_ff);
              nxt_ptr   = op_addr_ff[ADDR_W-1:0] & ADDR_W'(~(erase_size(op_kind_ff) - (ADDR_W+1)'(1)));
              nxt_state = sflash_pkg::ENG_ERASE;
            end
          end
        end
      end
      sflash_pkg::ENG_PROG: begin
        mem_we   = 1'b1;
        mem_wa   = {ptr_ff[ADDR_W-1:8], pofs_ff};
        mem_wd   = mem[mem_wa] & pdat;
        nxt_fail = fail_ff | (mem_wd != pdat);
        nxt_pofs = pofs_ff + 8'h01;
      end
      sflash_pkg::ENG_OTP: begin
        otp_wd   = otp[otp_wa] & pdat;
        otp_we   = otp_wa >= 7'(sflash_pkg::OTP_FACTORY_BYTES);
        nxt_fail = fail_ff | ~otp_we | (otp_wd != pdat);
        nxt_pofs = pofs_ff + 8'h01;  // Follows the page buffer; the index wraps in 128 via otp_wa
      end
      default: begin
        mem_we  = 1'b1;
        nxt_ptr = ptr_ff + ADDR_W'(1);
      end
    endcase
    if (state_ff != sflash_pkg::ENG_IDLE) begin
      nxt_left = left_ff - (ADDR_W+1)'(1);
      if (left_ff == (ADDR_W+1)'(1)) begin
        nxt_state = sflash_pkg::ENG_IDLE;
        nxt_wel   = 1'b0;
      end
    end
    nxt_busy    = nxt_state != sflash_pkg::ENG_IDLE;
    nxt_standby = cs_s & ~nxt_busy;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cs_d_ff    <= sflash_pkg::CS_IDLE;
      state_ff   <= sflash_pkg::ENG_IDLE;
      wel_ff     <= 1'b0;
      fail_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      standby_ff <= 1'b1;
      ptr_ff     <= '0;
      left_ff    <= '0;
      pofs_ff    <= 8'h00;
    end else begin
      cs_d_ff    <= nxt_cs_d;
      state_ff   <= nxt_state;
      wel_ff     <= nxt_wel;
      fail_ff    <= nxt_fail;
      busy_ff    <= nxt_busy;
      standby_ff <= nxt_standby;
      ptr_ff     <= nxt_ptr;
      left_ff    <= nxt_left;
      pofs_ff    <= nxt_pofs;
    end
  end

  // Reset stands in for power-up contents: erased array, seeded identifier
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= sflash_pkg::ERASED_BYTE;
      end
      for (int j = 0; j < sflash_pkg::OTP_BYTES; j++) begin
        otp[j] <= (j < sflash_pkg::OTP_FACTORY_BYTES) ? (sflash_pkg::OTP_ID_SEED ^ 8'(j)) : sflash_pkg::ERASED_BYTE;
      end
    end else begin
      if (mem_we) begin
        mem[mem_wa] <= mem_wd;
      end
      if (otp_we) begin
        otp[otp_wa] <= otp_wd;
      end
    end
  end

  assign SO                 = so_ff;
  assign SO_OE_N            = so_oe_n_ff;
  assign DUAL_LANE_LOW      = lo_ff;
  assign DUAL_LANE_LOW_OE_N = lo_oe_n_ff;
  assign STANDBY            = standby_ff;
  assign BUSY               = busy_ff;
endmodule

//--- tb/sflash_asserts.sv
// Purpose: Port checker for the serial flash front end.
// Assumes: Sampled on CORE_CLK; outputs float without a clock.
// Notes:   Bit launch timing is judged through the host model.
`timescale 1ns/1ps
module sflash_asserts (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic HOLD_N,
  input wire logic SI_IN,
  input wire logic DUAL_LANE_LOW,
  input wire logic DUAL_LANE_LOW_OE_N,
  input wire logic SO,
  input wire logic SO_OE_N,
  input wire logic STANDBY,
  input wire logic BUSY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_so_float; CS_N |-> SO_OE_N; endproperty
  a_so_float: assert property (p_so_float) else $error("so driven while idle");
  property p_lane_float; CS_N |-> DUAL_LANE_LOW_OE_N; endproperty
  a_lane_float: assert property (p_lane_float) else $error("input pin driven while idle");
  property p_hold_float; !HOLD_N |-> SO_OE_N && DUAL_LANE_LOW_OE_N; endproperty
  a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");
  property p_busy_standby; BUSY |-> !STANDBY; endproperty
  a_busy_standby: assert property (p_busy_standby) else $error("standby while busy");
  property p_standby_enter; (CS_N && !BUSY) [*8] |-> STANDBY; endproperty
  a_standby_enter: assert property (p_standby_enter) else $error("no standby when idle");
  property p_standby_leave; !CS_N [*5] |-> !STANDBY; endproperty
  a_standby_leave: assert property (p_standby_leave) else $error("standby while selected");
  property p_busy_start; $rose(BUSY) |-> CS_N; endproperty
  a_busy_start: assert property (p_busy_start) else $error("engine began in a frame");
  property p_dual_pair; !DUAL_LANE_LOW_OE_N |-> !SO_OE_N; endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("dual lane without high lane");
  // A whole command byte takes longer than five core cycles
  property p_fresh_cmd; $fell(CS_N) |-> SO_OE_N [*5]; endproperty
  a_fresh_cmd: assert property (p_fresh_cmd) else $error("output before command byte");
endmodule
bind serial_flash_pin_interface sflash_asserts sflash_asserts_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .HOLD_N(HOLD_N), .SI_IN(SI_IN),
  .DUAL_LANE_LOW(DUAL_LANE_LOW), .DUAL_LANE_LOW_OE_N(DUAL_LANE_LOW_OE_N), .SO(SO),
  .SO_OE_N(SO_OE_N), .STANDBY(STANDBY), .BUSY(BUSY));

//--- tb/spi_host.sv
// Purpose: Behavioural SPI host driving the flash pins.
// Assumes: Link clock of 6 ns; clock stands still between frames.
// Notes:   Released input line shows the inverse of its last level.
`timescale 1ns/1ps
module spi_host (
  output logic      sck,
  output logic      cs_n,
  output logic      hold_n,
  output logic      si_in,
  input  wire logic lane_low,
  input  wire logic lane_oe_n,
  input  wire logic so
);
  logic mode3 = 1'b0;
  logic drv = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    // Link-side flops see no reset edge at time zero; one pulse inside reset clears them
    #1 sck = 1'b1;
    #1 sck = 1'b0;
  end
  // Device owns the pin only while it enables its driver
  assign si_in = lane_oe_n ? drv : lane_low;
  task automatic set_mode(input logic m);
    mode3 = m;
    sck = m;
    #3;
  endtask
  task automatic open_frame();
    cs_n = 1'b0;
    #3;
  endtask
  task automatic close_frame();
    sck = mode3;
    #3;
    cs_n = 1'b1;
    drv = ~drv;
    // Core needs three clocks to see the rise
    #40;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      sck = 1'b0;
      drv = tx[7-i];
      #3 sck = 1'b1;
      rx = dual ? {rx[5:0], so, si_in} : {rx[6:0], so};
      #3;
    end
  endtask
  task automatic noise(input logic sel, input int n, input logic [7:0] pat);
    cs_n = ~sel;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      drv = pat[7-i];
      #3 sck = 1'b1;
      #3;
    end
    close_frame();
  endtask
  task automatic hold_pause();
    sck = 1'b0;
    #3 hold_n = 1'b0;
    repeat (3) begin
      #3 sck = 1'b1;
      drv = ~drv;
      #3 sck = 1'b0;
    end
    #3 hold_n = 1'b1;
    #3;
  endtask
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench of the serial flash pin front end.
// Assumes: Array reads erased after reset.
// Notes:   Large erases dominate the run time.
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sck;
  logic        cs_n;
  logic        hold_n;
  logic        si_in;
  logic        lane_low;
  logic        lane_oe_n;
  logic        so;
  logic        so_oe_n;
  logic        standby;
  logic        busy;
  logic [7:0]  rx;
  logic [7:0]  st;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  ecode [4] = '{8'h81, 8'h20, 8'h52, 8'h60};
  logic [23:0] eaddr [4] = '{24'h000200, 24'h001010, 24'h004321, 24'h007abc};
  always #4 core_clk = ~core_clk;
  serial_flash_pin_interface serial_flash_pin_interface_inst (
    .CORE_CLK(core_clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .HOLD_N(hold_n), .SI_IN(si_in),
    .DUAL_LANE_LOW(lane_low), .DUAL_LANE_LOW_OE_N(lane_oe_n), .SO(so), .SO_OE_N(so_oe_n),
    .STANDBY(standby), .BUSY(busy));
  spi_host spi_host_inst (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si_in(si_in),
    .lane_low(lane_low), .lane_oe_n(lane_oe_n), .so(so));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] a, input int na);
    spi_host_inst.open_frame();
    spi_host_inst.xfer(c, 1'b0, rx);
    for (int i = 0; i < na; i++) begin
      spi_host_inst.xfer(a[23-8*i -: 8], 1'b0, rx);
    end
  endtask
  task automatic wait_idle();
    cmd(sflash_pkg::CMD_STATUS, 24'h0, 0);
    st = 8'hff;
    for (int i = 0; i < 8000 && st[sflash_pkg::STAT_BUSY_BIT] !== 1'b0; i++) begin
      spi_host_inst.xfer(8'h00, 1'b0, st);
    end
    // Status bits leave at different falls, so the byte after busy clears is the settled one
    spi_host_inst.xfer(8'h00, 1'b0, st);
    chk(st & 8'h01, 8'h00, "busy poll");
    spi_host_inst.close_frame();
  endtask
  task automatic prog(input logic [7:0] c, input logic [23:0] a, input int n, input logic [7:0] d);
    cmd(sflash_pkg::CMD_WRITE_EN, 24'h0, 0);
    spi_host_inst.close_frame();
    cmd(c, a, (c == sflash_pkg::CMD_ERASE_CHIP) ? 0 : 3);
    for (int i = 0; i < n; i++) begin
      spi_host_inst.xfer(d + 8'(i), 1'b0, rx);
    end
    spi_host_inst.close_frame();
    wait_idle();
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [23:0] a, input int n, input logic [7:0] e);
    logic dual;
    dual = (c == sflash_pkg::CMD_READ_DUAL);
    cmd(c, a, 3);
    if (dual) begin
      spi_host_inst.xfer(8'h00, 1'b0, rx);
    end
    for (int i = 0; i < n; i++) begin
      spi_host_inst.xfer(8'h00, dual, rx);
      chk(rx, e + 8'(i), "read");
    end
    spi_host_inst.close_frame();
  endtask
  task automatic t_idle_desel();
    chk({4'h0, standby, busy, so_oe_n, lane_oe_n}, 8'h0b, "idle pins");
    spi_host_inst.noise(1'b0, 8, sflash_pkg::CMD_WRITE_EN);
    spi_host_inst.noise(1'b1, 5, 8'h00);
    wait_idle();
    chk(st, 8'h00, "status");
    $display("test idle done");
  endtask
  task automatic t_otp();
    rd_chk(sflash_pkg::CMD_OTP_READ, 24'h3f, 1, sflash_pkg::OTP_ID_SEED ^ 8'h3f);
    spi_host_inst.open_frame();
    spi_host_inst.xfer(sflash_pkg::CMD_OTP_READ, 1'b0, rx);
    spi_host_inst.hold_pause();
    spi_host_inst.xfer(8'h00, 1'b0, rx);
    spi_host_inst.xfer(8'h00, 1'b0, rx);
    spi_host_inst.xfer(8'h10, 1'b0, rx);
    spi_host_inst.xfer(8'h00, 1'b0, rx);
    chk(rx, sflash_pkg::OTP_ID_SEED ^ 8'h10, "hold read");
    spi_host_inst.close_frame();
    prog(sflash_pkg::CMD_OTP_PROG, 24'h40, 1, 8'h3c);
    chk(st, 8'h00, "otp status");
    rd_chk(sflash_pkg::CMD_OTP_READ, 24'h40, 1, 8'h3c);
    prog(sflash_pkg::CMD_OTP_PROG, 24'h3e, 1, 8'h00);
    chk(st, 8'h20, "otp fail");
    rd_chk(sflash_pkg::CMD_OTP_READ, 24'h3e, 1, sflash_pkg::OTP_ID_SEED ^ 8'h3e);
    $display("test otp done");
  endtask
  task automatic t_prog();
    prog(sflash_pkg::CMD_PROG, 24'h0200, 256, 8'h00);
    chk(st, 8'h00, "page status");
    rd_chk(sflash_pkg::CMD_READ, 24'h02fe, 2, 8'hfe);
    prog(sflash_pkg::CMD_PROG, 24'h0300, 1, 8'ha5);
    rd_chk(sflash_pkg::CMD_READ, 24'h0300, 1, 8'ha5);
    rd_chk(sflash_pkg::CMD_READ, 24'h0301, 1, 8'hff);
    spi_host_inst.set_mode(1'b1);
    rd_chk(sflash_pkg::CMD_READ_DUAL, 24'h0210, 4, 8'h10);
    rd_chk(sflash_pkg::CMD_READ, 24'h0280, 2, 8'h80);
    spi_host_inst.set_mode(1'b0);
    prog(sflash_pkg::CMD_PROG, 24'h0200, 1, 8'h01);
    chk(st, 8'h20, "prog fail");
    $display("test prog done");
  endtask
  task automatic t_erase();
    for (int k = 0; k < 4; k++) begin
      prog(sflash_pkg::CMD_PROG, eaddr[k], 1, 8'h00);
      prog(ecode[k], eaddr[k], 0, 8'h00);
      chk(st, 8'h00, "erase status");
      rd_chk(sflash_pkg::CMD_READ, eaddr[k], 1, 8'hff);
      if (k == 0) begin
        rd_chk(sflash_pkg::CMD_READ, 24'h0300, 1, 8'ha5);
      end
    end
    $display("test erase done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ceiling sits above the two full-array erases
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_idle_desel();
    t_otp();
    t_prog();
    t_erase();
    complete_run();
  end
endmodule
